// ---- prs_sequencer.sv ----
/*
 * Programmed run sequencer: reference time counter, three groups of ten
 * points, contact-input start logic and power-failure behaviour.
 * Assumes contact inputs are debounced and synchronous to core_clk, and
 * that core_clk keeps running from the backup supply while power_good is low.
 */
module prs_sequencer
   import prs_pkg::*;
#(
   parameter int unsigned CYCLES_PER_SEC = CYCLES_PER_SECOND
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic group1_select_input,
   input wire logic group2_select_input,
   input wire logic group3_select_input,
   input wire logic program_start_input,
   input wire logic timer_reset_input,
   input wire logic [3:0] run_mode_selection,
   input wire logic [1:0] time_unit_selection,
   input wire logic preset_we,
   input wire logic [13:0] reference_time_preset,
   input wire prs_point_wr_t point_wr,
   input wire logic power_good,
   input wire logic battery_fitted,
   output logic time_out_output,
   output logic group1_active_output,
   output logic group2_active_output,
   output logic group3_active_output,
   output prs_drive_t drive,
   output logic [13:0] ref_time_monitor
);

   // ************************************************************
   // Declarations
   // ************************************************************
   localparam int CW = $clog2(CYCLES_PER_SEC);
   prs_point_t points [POINT_COUNT];
   prs_state_t state;
   logic [1:0] grp;
   logic [3:0] idx;
   logic [2:0] mask;
   logic [2:0] sel_saved;
   logic [13:0] ref_time;
   logic [13:0] preset;
   logic [CW-1:0] cyc;
   logic [5:0] sec_in_min;
   logic [16:0] outage;
   logic start_prev;
   logic treset_prev;
   logic power_prev;
   prs_drive_t applied;
   logic [2:0] sel;
   logic [2:0] rest;
   logic [4:0] addr;
   prs_point_t cur;
   logic unit_tick;
   logic minutes;
   logic trigger;
   logic grp_done;
   logic advance;
   logic loss_clear;
   logic restore;
   logic over_limit;
   logic reselect;

   // All checks below run on the core clock and rest during reset
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);

   // Lowest set group of a mask
   function automatic logic [1:0] first_grp(input logic [2:0] m);
      logic [1:0] g;
      g = 2'h2;
      if (m[1]) begin
         g = 2'h1;
      end
      if (m[0]) begin
         g = 2'h0;
      end
      return g;
   endfunction

   // ************************************************************
   // Point storage
   // ************************************************************
   // Each entry loads on a matching write strobe
   for (genvar i = 0; i < POINT_COUNT; i++) begin : g_pt
      always_ff @(posedge core_clk or posedge rst) begin
         if (rst) begin
            points[i] <= '0;
         end else if (point_wr.we && point_wr.index < 4'(POINTS_PER_GROUP) && point_wr.group < 2'(GROUPS)
                      && 5'({3'h0, point_wr.group} * 5'h0A) + {1'h0, point_wr.index} == 5'(i)) begin
            points[i] <= point_wr.point;
         end
      end
   end

   // ************************************************************
   // Decode of inputs and sequencing conditions
   // ************************************************************
   // Start edges, advance and power events
   always_comb begin
      sel = {group3_select_input, group2_select_input, group1_select_input};
      minutes = time_unit_selection[UNIT_MINUTE_BIT];
      addr = 5'({3'h0, grp} * 5'h0A) + {1'h0, idx};
      cur = (idx < 4'(POINTS_PER_GROUP)) ? points[addr] : '0;
      // Restart after a timer reset release lets a fed-back time-out repeat
      trigger = ((program_start_input && !start_prev)
                 || (program_start_input && treset_prev && !timer_reset_input))
                && sel != 3'h0 && !timer_reset_input
                && run_mode_selection == RUN_MODE_PROGRAM && power_good;
      grp_done = !cur.valid;
      rest = mask & ~((3'h2 << grp) - 3'h1);
      restore = power_good && !power_prev && battery_fitted;
      over_limit = outage > (minutes ? OUTAGE_LIMIT_MIN_UNITS : OUTAGE_LIMIT_SEC_UNITS);
      reselect = restore && state == PRS_RUN && !over_limit && sel != 3'h0 && sel != sel_saved;
      advance = (state == PRS_RUN && grp_done && rest != 3'h0) || reselect;
      loss_clear = !power_good && !battery_fitted;
   end

   // ************************************************************
   // Time base
   // ************************************************************
   // Seconds from the clock, minutes from seconds
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cyc <= '0;
         sec_in_min <= 6'h00;
      end else if (cyc == CW'(CYCLES_PER_SEC - 1)) begin
         cyc <= '0;
         sec_in_min <= (sec_in_min == SECONDS_PER_MINUTE - 6'h01) ? 6'h00 : sec_in_min + 6'h01;
      end else begin
         cyc <= cyc + CW'(1);
      end
   end

   assign unit_tick = cyc == CW'(CYCLES_PER_SEC - 1)
                      && (!minutes || sec_in_min == SECONDS_PER_MINUTE - 6'h01);

   // ************************************************************
   // Reference time counter and preset
   // ************************************************************
   // Clear on reset, start or group change; keeps counting on battery
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ref_time <= TIME_RESET;
         preset <= TIME_RESET;
      end else if (timer_reset_input || loss_clear) begin
         ref_time <= TIME_RESET;
         preset <= TIME_RESET;
      end else if (trigger) begin
         ref_time <= TIME_RESET;
         preset <= TIME_RESET;
      end else if (advance) begin
         ref_time <= TIME_RESET;
      end else if (preset_we) begin
         ref_time <= reference_time_preset;
         preset <= reference_time_preset;
      end else if (state == PRS_RUN && unit_tick && ref_time != TIME_MAX) begin
         ref_time <= ref_time + 14'h0001;
      end
   end

   // ************************************************************
   // Outage length and edge history
   // ************************************************************
   // Counts time units while power is down, saturating
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         outage <= 17'h00000;
      end else if (power_good) begin
         outage <= 17'h00000;
      end else if (unit_tick && outage != 17'h1FFFF) begin
         outage <= outage + 17'h00001;
      end
   end

   // Start history forced high during loss so a held start cannot resume
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         start_prev <= 1'b1;
         treset_prev <= 1'b0;
         power_prev <= 1'b1;
      end else begin
         start_prev <= program_start_input || !power_good;
         treset_prev <= timer_reset_input;
         power_prev <= power_good;
      end
   end

   // ************************************************************
   // Sequencer
   // ************************************************************
   // Steps points by time, walks groups, handles power events
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state <= PRS_IDLE;
         grp <= 2'h0;
         idx <= 4'h0;
         mask <= 3'h0;
         sel_saved <= 3'h0;
         applied <= '0;
      end else if (timer_reset_input || loss_clear) begin
         state <= PRS_IDLE;
         idx <= 4'h0;
         applied <= '0;
      end else if (trigger) begin
         state <= PRS_RUN;
         mask <= sel;
         sel_saved <= sel;
         grp <= first_grp(sel);
         idx <= 4'h0;
         applied <= '0;
      end else if (restore && state == PRS_RUN && over_limit) begin
         state <= PRS_IDLE;
         applied <= '0;
      end else if (reselect) begin
         mask <= sel;
         sel_saved <= sel;
         grp <= first_grp(sel);
         idx <= 4'h0;
         applied <= '0;
      end else begin
         unique case (state)
            PRS_IDLE: begin
               applied <= '0;
            end
            PRS_RUN: begin
               if (grp_done) begin
                  applied <= '0;
                  if (rest != 3'h0) begin
                     grp <= first_grp(rest);
                     idx <= 4'h0;
                  end else begin
                     state <= PRS_DONE;
                  end
               end else if (ref_time >= cur.start_time) begin
                  // Passed points are stepped over while power is down
                  applied <= '{dir: cur.dir, freq: cur.freq};
                  idx <= idx + 4'h1;
               end
            end
            PRS_DONE: begin
               applied <= '0;
            end
         endcase
      end
   end

   // ************************************************************
   // Registered outputs
   // ************************************************************
   // Outputs other than ref_time_monitor released while power is down
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         time_out_output <= 1'b0;
         group1_active_output <= 1'b0;
         group2_active_output <= 1'b0;
         group3_active_output <= 1'b0;
         drive <= '0;
         ref_time_monitor <= TIME_RESET;
      end else begin
         time_out_output <= state == PRS_DONE && power_good;
         group1_active_output <= state == PRS_RUN && grp == 2'h0 && power_good;
         group2_active_output <= state == PRS_RUN && grp == 2'h1 && power_good;
         group3_active_output <= state == PRS_RUN && grp == 2'h2 && power_good;
         drive <= power_good ? applied : '0;
         ref_time_monitor <= ref_time;
      end
   end

   // ************************************************************
   // Assertions
   // ************************************************************
   a_timeout_held: assert property (time_out_output && state == PRS_DONE && power_good
                                    |=> time_out_output)
      else $error("time-out dropped without timer reset");
   a_str_clears: assert property (timer_reset_input |=> ref_time == TIME_RESET && preset == TIME_RESET
                                  ##1 !time_out_output)
      else $error("timer reset did not clear time and time-out");
   a_start_clears: assert property (trigger |=> state == PRS_RUN && ref_time == TIME_RESET && idx == 4'h0)
      else $error("start did not clear timer and run");
   a_reset_blocks: assert property (state == PRS_IDLE && timer_reset_input |=> state == PRS_IDLE)
      else $error("run began under timer reset");
   a_mode_gate: assert property (state == PRS_IDLE && run_mode_selection != RUN_MODE_PROGRAM
                                 |=> state == PRS_IDLE)
      else $error("run began outside program mode");
   a_group_order: assert property (state == PRS_RUN && advance && !reselect && !restore
                                   && !timer_reset_input && !loss_clear && !trigger
                                   |=> grp > $past(grp) && ref_time == TIME_RESET)
      else $error("groups not in ascending order with cleared timer");
   a_last_timeout: assert property (state == PRS_RUN && grp_done && rest == 3'h0
                                    && !timer_reset_input && power_good && !restore && !trigger
                                    |=> ##1 (time_out_output || !$past(power_good)))
      else $error("time-out not raised after last group");
   a_loss_clears: assert property (loss_clear |=> state == PRS_IDLE && ref_time == TIME_RESET)
      else $error("power loss without battery did not clear");
   a_no_resume: assert property (state == PRS_IDLE && program_start_input && $rose(power_good)
                                 && !treset_prev |=> state == PRS_IDLE)
      else $error("held start resumed after power return");
   a_limit_stop: assert property (restore && state == PRS_RUN && over_limit && !timer_reset_input
                                  |=> state == PRS_IDLE)
      else $error("resumed after outage beyond limit");
   a_done_stays: assert property (restore && state == PRS_DONE && !timer_reset_input
                                  |=> state == PRS_DONE)
      else $error("operation resumed after time-out");
   a_active_onehot: assert property ($onehot0({group3_active_output, group2_active_output,
                                               group1_active_output}))
      else $error("more than one group active output");

   c_multi_group: cover property (state == PRS_RUN && advance && !reselect);
   c_timeout: cover property ($rose(time_out_output));
   c_battery_resume: cover property (restore && state == PRS_RUN && !over_limit && !reselect);
   c_reselect: cover property (reselect);

endmodule

// ---- prs_pkg.sv ----
/*
 * Constants, types and state encoding for the programmed run sequencer.
 * Assumes a single 50 MHz core clock and a crystal-accurate time base.
 */
// Overview of operation
// - Time-out set after group completes, held till reset
// - Start rise with group selected clears timer, runs
// - No start while timer reset held active
// - Runs only when run mode equals five
// - Several groups run ascending: one, two, three
// - Timer cleared between groups; time-out after last
// - Without battery, power loss clears, no auto resume
// - Restart needs start off then on; timer zeroed
// - With battery, timer keeps counting; missed points skipped
// - With battery, changed selection restarts from first point
// - With battery, no resume once time-out was raised
// - With battery, outage beyond limit stops resume
// - Points hold direction, frequency, time; three by ten
// - Timer reset or device reset zeroes timer, preset
// - Unit selection picks minutes:seconds or hours:minutes
package prs_pkg;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int unsigned CLK_PERIOD_NS = 20;
   localparam int unsigned SECOND_NS = 1_000_000_000;
   localparam int unsigned CYCLES_PER_SECOND = SECOND_NS / CLK_PERIOD_NS;
   localparam logic [5:0] SECONDS_PER_MINUTE = 6'h3C;
   localparam int unsigned OUTAGE_LIMIT_HOURS = 18;
   localparam int unsigned OUTAGE_LIMIT_DAYS = 30;
   localparam logic [16:0] OUTAGE_LIMIT_SEC_UNITS = 17'(OUTAGE_LIMIT_HOURS * 3600);
   localparam logic [16:0] OUTAGE_LIMIT_MIN_UNITS = 17'(OUTAGE_LIMIT_DAYS * 24 * 60);

   // ************************************************************
   // Sizes, codes and reset values
   // ************************************************************
   localparam int unsigned GROUPS = 3;
   localparam int unsigned POINTS_PER_GROUP = 10;
   localparam int unsigned POINT_COUNT = GROUPS * POINTS_PER_GROUP;
   localparam logic [3:0] RUN_MODE_PROGRAM = 4'h5;
   localparam int unsigned UNIT_MINUTE_BIT = 0;
   localparam logic [13:0] TIME_MAX = 14'h176F;
   localparam logic [13:0] TIME_RESET = 14'h0000;
   localparam logic [10:0] FREQ_RESET = 11'h000;

   typedef enum logic [1:0] {
      PRS_DIR_STOP = 2'h0,
      PRS_DIR_FWD = 2'h1,
      PRS_DIR_REV = 2'h2
   } prs_dir_t;

   typedef enum logic [1:0] {PRS_IDLE, PRS_RUN, PRS_DONE} prs_state_t;

   // One programmed point: time is a count of the selected unit
   typedef struct packed {
      logic valid;
      prs_dir_t dir;
      logic [10:0] freq;
      logic [13:0] start_time;
   } prs_point_t;

   // Point programming strobe with its address
   typedef struct packed {
      logic we;
      logic [1:0] group;
      logic [3:0] index;
      prs_point_t point;
   } prs_point_wr_t;

   // Drive command to the output stage
   typedef struct packed {
      prs_dir_t dir;
      logic [10:0] freq;
   } prs_drive_t;

endpackage

// ---- prs_contact_model.sv ----
/*
 * Contact-side model of the control equipment around the programmed run
 * sequencer: group select, start and timer-reset contacts, plus the
 * optional feedback of the time-out output into the timer-reset contact.
 * Assumes the bench gives plain requests on core_clk and holds them.
 */
module prs_contact_model (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [2:0] grp_req,
   input wire logic start_req,
   input wire logic reset_req,
   input wire logic repeat_en,
   input wire logic time_out_output,
   output logic group1_select_input,
   output logic group2_select_input,
   output logic group3_select_input,
   output logic program_start_input,
   output logic timer_reset_input
);
   timeunit 1ns;
   timeprecision 1ps;

   // ************************************************************
   // Contact drivers
   // ************************************************************
   // Start only closes once a group contact was already closed a cycle earlier
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         group1_select_input <= 1'b0;
         group2_select_input <= 1'b0;
         group3_select_input <= 1'b0;
         program_start_input <= 1'b0;
         timer_reset_input <= 1'b0;
      end else begin
         group1_select_input <= grp_req[0];
         group2_select_input <= grp_req[1];
         group3_select_input <= grp_req[2];
         program_start_input <= start_req & (group1_select_input | group2_select_input | group3_select_input);
         timer_reset_input <= reset_req | (repeat_en & time_out_output);
      end
   end
endmodule

// ---- program_run_sequencer_tb.sv ----
/*
 * Self-checking bench for the programmed run sequencer.
 * Assumes the contact model drives the contacts and a shortened second
 * of four core_clk cycles; times are seconds units unless a scenario picks minutes.
 */
module program_run_sequencer_tb
   import prs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TO = 0;
   localparam int G1 = 1;
   localparam int G2 = 2;
   localparam int G3 = 3;
   localparam int DRV = 4;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [2:0] grp_req = 3'h0;
   logic start_req = 1'b0;
   logic reset_req = 1'b0;
   logic repeat_en = 1'b0;
   logic g1_sel, g2_sel, g3_sel, start_in, treset_in;
   logic [3:0] run_mode_selection = 4'h5;
   logic [1:0] time_unit_selection = 2'h0;
   logic preset_we = 1'b0;
   logic [13:0] reference_time_preset = 14'h0000;
   prs_point_wr_t point_wr = '0;
   logic power_good = 1'b1;
   logic battery_fitted = 1'b0;
   logic time_out_output, g1_act, g2_act, g3_act;
   prs_drive_t drive, exp_drv;
   logic [13:0] ref_time_monitor;
   int n_fail = 0;
   int checks_done = 0;
   int cyc = 0;

   // ************************************************************
   // Clock, reset, instances, watchdog
   // ************************************************************
   // 50 MHz core clock
   always #10 core_clk = ~core_clk;

   prs_contact_model i_prs_contact_model (.core_clk(core_clk), .rst(rst), .grp_req(grp_req),
      .start_req(start_req), .reset_req(reset_req), .repeat_en(repeat_en), .time_out_output(time_out_output),
      .group1_select_input(g1_sel), .group2_select_input(g2_sel), .group3_select_input(g3_sel),
      .program_start_input(start_in), .timer_reset_input(treset_in));

   prs_sequencer #(.CYCLES_PER_SEC(4)) i_prs_sequencer (.core_clk(core_clk), .rst(rst),
      .group1_select_input(g1_sel), .group2_select_input(g2_sel), .group3_select_input(g3_sel),
      .program_start_input(start_in), .timer_reset_input(treset_in), .run_mode_selection(run_mode_selection),
      .time_unit_selection(time_unit_selection), .preset_we(preset_we), .reference_time_preset(reference_time_preset),
      .point_wr(point_wr), .power_good(power_good), .battery_fitted(battery_fitted),
      .time_out_output(time_out_output), .group1_active_output(g1_act), .group2_active_output(g2_act),
      .group3_active_output(g3_act), .drive(drive), .ref_time_monitor(ref_time_monitor));

   // Cuts a hang short
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         close_out();
      end
   end

   // ************************************************************
   // Shared tasks
   // ************************************************************
   task automatic close_out();
      $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask

   function automatic logic probe(input int k);
      case (k)
         TO: return time_out_output;
         G1: return g1_act;
         G2: return g2_act;
         G3: return g3_act;
         default: return drive === exp_drv;
      endcase
   endfunction

   // Waits a bounded number of cycles for a watched output to reach v
   task automatic wait_for(input int k, input logic v, input int lim);
      for (int i = 0; i < lim && probe(k) !== v; i++) begin
         @(posedge core_clk);
         #1;
      end
      chk(probe(k), v);
   endtask

   // Checks that a watched output stays at v for n cycles
   task automatic hold(input int k, input logic v, input int n);
      logic ok;
      ok = 1'b1;
      repeat (n) begin
         @(posedge core_clk);
         #1;
         if (probe(k) !== v) ok = 1'b0;
      end
      chk(ok, 1'b1);
   endtask

   task automatic put_pt(input logic [1:0] g, input logic [3:0] i, input prs_dir_t d, input logic [10:0] f,
                         input logic [13:0] t);
      @(posedge core_clk);
      point_wr <= {1'b1, g, i, 1'b1, d, f, t};
      @(posedge core_clk);
      point_wr <= '0;
   endtask

   task automatic go(input logic [2:0] g);
      @(posedge core_clk);
      grp_req <= g;
      start_req <= 1'b1;
   endtask

   // Opens start first, then pulses the timer reset contact
   task automatic idle();
      @(posedge core_clk);
      start_req <= 1'b0;
      grp_req <= 3'h0;
      repeat (2) @(posedge core_clk);
      reset_req <= 1'b1;
      repeat (3) @(posedge core_clk);
      reset_req <= 1'b0;
      repeat (2) @(posedge core_clk);
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic s_single();
      go(3'h1);
      wait_for(G1, 1'b1, 8);
      exp_drv = {PRS_DIR_FWD, 11'h064};
      wait_for(DRV, 1'b1, 4);
      exp_drv = {PRS_DIR_REV, 11'h0C8};
      wait_for(DRV, 1'b1, 20);
      wait_for(TO, 1'b1, 10);
      chk(g1_act, 1'b0);
      hold(TO, 1'b1, 30);
      @(posedge core_clk);
      start_req <= 1'b0;
      reset_req <= 1'b1;
      wait_for(TO, 1'b0, 5);
      #20;
      chk(ref_time_monitor, 14'h0000);
      idle();
   endtask

   task automatic s_refused();
      run_mode_selection <= 4'h4;
      go(3'h1);
      hold(G1, 1'b0, 20);
      idle();
      run_mode_selection <= 4'h5;
      reset_req <= 1'b1;
      go(3'h1);
      hold(G1, 1'b0, 20);
      idle();
   endtask

   task automatic s_multi();
      go(3'h5);
      wait_for(G1, 1'b1, 8);
      wait_for(G1, 1'b0, 40);
      chk(time_out_output, 1'b0);
      wait_for(G3, 1'b1, 4);
      chk(ref_time_monitor, 14'h0000);
      chk(g2_act, 1'b0);
      wait_for(TO, 1'b1, 30);
      idle();
   endtask

   task automatic s_power();
      battery_fitted <= 1'b0;
      go(3'h1);
      wait_for(G1, 1'b1, 8);
      @(posedge core_clk);
      power_good <= 1'b0;
      repeat (6) @(posedge core_clk);
      power_good <= 1'b1;
      hold(G1, 1'b0, 20);
      @(posedge core_clk);
      start_req <= 1'b0;
      repeat (3) @(posedge core_clk);
      start_req <= 1'b1;
      wait_for(G1, 1'b1, 8);
      chk(ref_time_monitor, 14'h0000);
      idle();
      battery_fitted <= 1'b1;
      go(3'h1);
      wait_for(TO, 1'b1, 40);
      @(posedge core_clk);
      power_good <= 1'b0;
      repeat (10) @(posedge core_clk);
      power_good <= 1'b1;
      hold(G1, 1'b0, 10);
      chk(time_out_output, 1'b1);
      idle();
      go(3'h1);
      wait_for(G1, 1'b1, 8);
      // Short outage so group 1 is still running when power returns
      @(posedge core_clk);
      power_good <= 1'b0;
      grp_req <= 3'h4;
      repeat (2) @(posedge core_clk);
      power_good <= 1'b1;
      wait_for(G3, 1'b1, 6);
      chk(g1_act, 1'b0);
      idle();
      battery_fitted <= 1'b0;
   endtask

   task automatic s_repeat_preset();
      repeat_en <= 1'b1;
      go(3'h1);
      wait_for(TO, 1'b1, 40);
      wait_for(G1, 1'b1, 10);
      @(posedge core_clk);
      repeat_en <= 1'b0;
      idle();
      go(3'h1);
      wait_for(G1, 1'b1, 8);
      @(posedge core_clk);
      preset_we <= 1'b1;
      reference_time_preset <= 14'h0032;
      @(posedge core_clk);
      preset_we <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      chk(ref_time_monitor >= 14'h0032, 1'b1);
      idle();
   endtask

   // Minute units: a point at two units must not fire within seconds
   task automatic s_units();
      time_unit_selection <= 2'h1;
      exp_drv = {PRS_DIR_REV, 11'h01E};
      go(3'h2);
      wait_for(G2, 1'b1, 8);
      hold(DRV, 1'b0, 200);
      wait_for(DRV, 1'b1, 300);
      wait_for(TO, 1'b1, 10);
      idle();
      time_unit_selection <= 2'h0;
   endtask

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      exp_drv = '0;
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
      put_pt(2'h0, 4'h0, PRS_DIR_FWD, 11'h064, 14'h0000);
      put_pt(2'h0, 4'h1, PRS_DIR_REV, 11'h0C8, 14'h0002);
      put_pt(2'h2, 4'h0, PRS_DIR_FWD, 11'h032, 14'h0001);
      put_pt(2'h1, 4'h0, PRS_DIR_REV, 11'h01E, 14'h0002);
      s_single();
      s_refused();
      s_multi();
      s_power();
      s_repeat_preset();
      s_units();
      close_out();
   end
endmodule
